// ---- sc_uart_pkg.sv ----
// Constants and types shared by the smart-card serial channel.
package sc_uart_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] CTL0_OFF = 8'h04;
  localparam logic [7:0] CTL1_OFF = 8'h08;
  localparam logic [7:0] BRG_OFF = 8'h0c;
  localparam logic [7:0] TXB_OFF = 8'h10;
  localparam logic [7:0] RXB_OFF = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_EXTCLK = 3;
  localparam int MODE_STOP2 = 4;
  localparam int MODE_EVEN = 5;
  localparam int MODE_PAREN = 6;
  localparam int MODE_POLREV = 7;
  localparam int C0_TXEPT = 3;
  localparam int C0_FLOWDIS = 4;
  localparam int C0_OPENDR = 5;
  localparam int C0_MSB = 7;
  localparam int C1_TE = 0;
  localparam int C1_TI = 1;
  localparam int C1_RE = 2;
  localparam int C1_RI = 3;
  localparam int C1_IRS = 4;
  localparam int C1_LOGINV = 6;
  localparam int C1_ESE = 7;
  localparam int RXB_OER = 12;
  localparam int RXB_FER = 13;
  localparam int RXB_PER = 14;
  localparam int RXB_SUM = 15;

  // ----------------------------------------------------------------
  // Values and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_ASYNC8 = 3'h5;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] BRG_RST = 8'h00;
  localparam logic [7:0] CTL0_WMASK = 8'hb3;
  localparam logic [7:0] CTL1_WMASK = 8'hd5;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [3:0] PH_LAST = 4'hf;
  localparam logic [3:0] PH_HALF = 4'h7;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [4:0] PRE_DIV1_MAX = 5'h00;
  localparam logic [4:0] PRE_DIV2_MAX = 5'h01;
  localparam logic [4:0] PRE_DIV8_MAX = 5'h07;
  localparam logic [4:0] PRE_DIV32_MAX = 5'h1f;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GUARD
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_e;

endpackage

// ---- bit_tick_gen.sv ----
// Prescaler and bit-rate divider giving a tick at sixteen times bit rate.
`timescale 1ns/1ps
`default_nettype none
module bit_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] clk_sel,
  input wire logic [7:0] divisor,
  output logic tick
);
  import sc_uart_pkg::*;

  typedef struct packed {
    logic [4:0] pre_cnt;
    logic [7:0] div_cnt;
    logic tick;
  } tick_s;

  tick_s st_r;
  tick_s st_nxt;
  logic [4:0] pre_max;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    // Internal source only; an external clock is never taken
    case (clk_sel)
      2'h0: pre_max = PRE_DIV1_MAX;
      2'h1: pre_max = PRE_DIV2_MAX;
      2'h2: pre_max = PRE_DIV8_MAX;
      default: pre_max = PRE_DIV32_MAX;
    endcase
    if (st_r.pre_cnt >= pre_max) begin
      st_nxt.pre_cnt = 5'h00;
      // Divide by n+1 here, by 16 in the channel
      if (st_r.div_cnt >= divisor) begin
        st_nxt.div_cnt = 8'h00;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 8'h01;
      end
    end else begin
      st_nxt.pre_cnt = st_r.pre_cnt + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule
`default_nettype wire

// ---- sc_uart.sv ----
// Third serial channel in smart-card async mode with an APB register port.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sc_uart (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic tx_irq,
  output logic rx_irq,
  output logic collision_irq
);
  import sc_uart_pkg::*;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] brg;
    logic [7:0] txbuf;
    logic ti;
    logic ri;
    logic txept;
    logic [7:0] rxbuf;
    logic oerr;
    logic ferr;
    logic perr;
    tx_state_e tx_st;
    logic [3:0] tx_ph;
    logic [3:0] tx_cnt;
    logic [7:0] tx_sh;
    logic tx_par;
    rx_state_e rx_st;
    logic [3:0] rx_ph;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sh;
    logic rx_pbad;
    logic err_act;
    logic [3:0] err_ph;
    logic out_pin;
    logic out_oe;
    logic tx_irq;
    logic rx_irq;
    logic col_irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } chan_s;

  chan_s st_r;
  chan_s st_nxt;
  logic tick;
  logic async_on;
  logic inv;
  logic msb;
  logic par_en;
  logic even;
  logic in_lvl;
  logic level;
  logic landed;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] a;

  bit_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clk_sel(st_r.c0[1:0]),
    .divisor(st_r.brg),
    .tick(tick)
  );

  // Parity bit that makes the chosen count of ones
  function automatic logic par_of(input logic [7:0] d, input logic ev);
    par_of = ev ? (^d) : ~(^d);
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_irq = 1'b0;
    st_nxt.rx_irq = 1'b0;
    st_nxt.col_irq = 1'b0;
    async_on = (st_r.mode[2:0] == MODE_ASYNC8);
    inv = st_r.c1[C1_LOGINV];
    msb = st_r.c0[C0_MSB];
    par_en = st_r.mode[MODE_PAREN];
    even = st_r.mode[MODE_EVEN];
    // Inverted pin sampled in the same polarity as driven
    in_lvl = serial_in_pin ^ st_r.mode[MODE_POLREV];
    landed = 1'b0;
    a = paddr[7:0];
    wr_ok = psel && penable && st_r.pready && pwrite;
    rd_ok = psel && penable && st_r.pready && !pwrite;

    // --------------------------------------------------------------
    // Transmitter
    // --------------------------------------------------------------
    case (st_r.tx_st)
      TX_IDLE: begin
        // Start only with enable set and data waiting
        if (async_on && st_r.c1[C1_TE] && !st_r.ti) begin
          st_nxt.tx_st = TX_START;
          st_nxt.tx_ph = 4'h0;
          st_nxt.tx_sh = st_r.txbuf;
          // Parity of the already-inverted buffer byte
          st_nxt.tx_par = par_of(st_r.txbuf, even);
          st_nxt.ti = 1'b1;
          st_nxt.txept = 1'b0;
          if (!st_r.c1[C1_IRS]) begin
            st_nxt.tx_irq = 1'b1;
          end
        end
      end
      default: begin
        if (tick) begin
          st_nxt.tx_ph = st_r.tx_ph + 4'h1;
          if (st_r.tx_st == TX_GUARD && st_r.tx_ph == PH_HALF) begin
            // Half a bit later when error signalling is on
            st_nxt.tx_st = TX_IDLE;
            st_nxt.txept = 1'b1;
            st_nxt.tx_irq = st_r.c1[C1_IRS];
          end else if (st_r.tx_ph == PH_LAST) begin
            st_nxt.tx_ph = 4'h0;
            case (st_r.tx_st)
              TX_START: begin
                st_nxt.tx_st = TX_DATA;
                st_nxt.tx_cnt = 4'h0;
              end
              TX_DATA: begin
                // Bit 0 first, or bit 7 first when MSB order
                st_nxt.tx_sh = msb ? {st_r.tx_sh[6:0], 1'b0}
                                   : {1'b0, st_r.tx_sh[7:1]};
                st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
                if (st_r.tx_cnt == DATA_BITS - 4'h1) begin
                  st_nxt.tx_st = par_en ? TX_PAR : TX_STOP;
                  st_nxt.tx_cnt = 4'h0;
                end
              end
              TX_PAR: begin
                st_nxt.tx_st = TX_STOP;
                st_nxt.tx_cnt = 4'h0;
              end
              TX_STOP: begin
                st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
                if (!st_r.mode[MODE_STOP2] || st_r.tx_cnt != 4'h0) begin
                  if (st_r.c1[C1_ESE]) begin
                    st_nxt.tx_st = TX_GUARD;
                  end else begin
                    // Raised once the last bit has left
                    st_nxt.tx_st = TX_IDLE;
                    st_nxt.txept = 1'b1;
                    st_nxt.tx_irq = st_r.c1[C1_IRS];
                  end
                end
              end
              default: st_nxt.tx_st = TX_IDLE;
            endcase
          end
        end
      end
    endcase

    // --------------------------------------------------------------
    // Receiver; no address-wakeup path, every frame lands
    // --------------------------------------------------------------
    case (st_r.rx_st)
      RX_IDLE: begin
        // Needs receive enable and a low start level
        if (async_on && st_r.c1[C1_RE] && !in_lvl) begin
          st_nxt.rx_st = RX_START;
          st_nxt.rx_ph = 4'h0;
        end
      end
      default: begin
        if (tick) begin
          st_nxt.rx_ph = st_r.rx_ph + 4'h1;
          if (st_r.rx_st == RX_START) begin
            if (st_r.rx_ph == PH_HALF) begin
              // A glitch shorter than half a bit is not a start
              st_nxt.rx_st = in_lvl ? RX_IDLE : RX_DATA;
              st_nxt.rx_ph = 4'h0;
              st_nxt.rx_cnt = 4'h0;
            end
          end else if (st_r.rx_ph == PH_LAST) begin
            st_nxt.rx_ph = 4'h0;
            case (st_r.rx_st)
              RX_DATA: begin
                st_nxt.rx_sh = msb ? {st_r.rx_sh[6:0], in_lvl}
                                   : {in_lvl, st_r.rx_sh[7:1]};
                st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
                st_nxt.rx_pbad = 1'b0;
                if (st_r.rx_cnt == DATA_BITS - 4'h1) begin
                  st_nxt.rx_st = par_en ? RX_PAR : RX_STOP;
                end
              end
              RX_PAR: begin
                st_nxt.rx_pbad = (in_lvl != par_of(st_r.rx_sh, even));
                st_nxt.rx_st = RX_STOP;
              end
              default: begin
                // Frame into the buffer, errors beside it
                st_nxt.rx_st = RX_IDLE;
                landed = 1'b1;
                st_nxt.rxbuf = st_r.rx_sh;
                st_nxt.ferr = !in_lvl;
                st_nxt.perr = st_r.rx_pbad;
                if (st_r.ri) begin
                  // Buffer overwritten, overrun flag set, ready flag left as it was
                  st_nxt.oerr = 1'b1;
                end else begin
                  // Flag and request on the buffer load
                  st_nxt.ri = 1'b1;
                  st_nxt.rx_irq = 1'b1;
                end
                if (st_r.rx_pbad && st_r.c1[C1_ESE]) begin
                  // One bit time of low level back to the card
                  st_nxt.err_act = 1'b1;
                  st_nxt.err_ph = 4'h0;
                end
              end
            endcase
          end
        end
      end
    endcase

    if (st_r.err_act && tick) begin
      st_nxt.err_ph = st_r.err_ph + 4'h1;
      if (st_r.err_ph == PH_LAST) begin
        st_nxt.err_act = 1'b0;
      end
    end

    // --------------------------------------------------------------
    // Line driver
    // --------------------------------------------------------------
    case (st_r.tx_st)
      TX_START: level = 1'b0;
      TX_DATA: level = msb ? st_r.tx_sh[7] : st_r.tx_sh[0];
      TX_PAR: level = st_r.tx_par;
      default: level = 1'b1;
    endcase
    if (st_r.err_act) begin
      level = 1'b0;
    end
    // Idle level is high (low when polarity reversed), released when open drain and high
    st_nxt.out_pin = level ^ st_r.mode[MODE_POLREV];
    st_nxt.out_oe = !st_r.c0[C0_OPENDR] || !st_nxt.out_pin;

    // Compare driven and seen level at mid bit
    if (tick && st_r.tx_st != TX_IDLE && st_r.tx_ph == PH_HALF &&
        st_r.out_pin != serial_in_pin) begin
      st_nxt.col_irq = 1'b1;
    end

    // --------------------------------------------------------------
    // APB slave, one wait state
    // --------------------------------------------------------------
    st_nxt.pready = psel && penable && !st_r.pready;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (psel && penable && !st_r.pready) begin
      if (a == MODE_OFF) begin
        st_nxt.prdata[7:0] = st_r.mode;
      end else if (a == CTL0_OFF) begin
        st_nxt.prdata[7:0] = st_r.c0;
        st_nxt.prdata[C0_TXEPT] = st_r.txept;
      end else if (a == CTL1_OFF) begin
        st_nxt.prdata[7:0] = st_r.c1;
        st_nxt.prdata[C1_TI] = st_r.ti;
        st_nxt.prdata[C1_RI] = st_r.ri;
      end else if (a == BRG_OFF) begin
        st_nxt.prdata[7:0] = st_r.brg;
      end else if (a == RXB_OFF) begin
        // Read path inverts when data logic select is set
        st_nxt.prdata[7:0] = st_r.rxbuf ^ {8{inv}};
        st_nxt.prdata[RXB_OER] = st_r.oerr;
        st_nxt.prdata[RXB_FER] = st_r.ferr;
        st_nxt.prdata[RXB_PER] = st_r.perr;
        st_nxt.prdata[RXB_SUM] = st_r.oerr | st_r.ferr | st_r.perr;
      end else if (a != TXB_OFF || paddr[31:8] != 24'h000000) begin
        st_nxt.pslverr = 1'b1;
      end
      if (paddr[31:8] != 24'h000000) begin
        st_nxt.pslverr = 1'b1;
      end
    end
    if (wr_ok && !st_r.pslverr) begin
      if (a == MODE_OFF) begin
        st_nxt.mode = pwdata[7:0];
        // Dropping out of async mode aborts any frame
        if (pwdata[2:0] != MODE_ASYNC8) begin
          st_nxt.tx_st = TX_IDLE;
          st_nxt.rx_st = RX_IDLE;
          st_nxt.txept = 1'b1;
        end
        // Clock source is forced internal
        st_nxt.mode[MODE_EXTCLK] = 1'b0;
      end else if (a == CTL0_OFF) begin
        st_nxt.c0 = pwdata[7:0] & CTL0_WMASK;
      end else if (a == CTL1_OFF) begin
        st_nxt.c1 = pwdata[7:0] & CTL1_WMASK;
        // An overrun landing in the same cycle wins over the clear
        if (!pwdata[C1_RE] && !landed) begin
          st_nxt.oerr = 1'b0;
        end
      end else if (a == BRG_OFF) begin
        st_nxt.brg = pwdata[7:0];
      end else if (a == TXB_OFF) begin
        // Written data inverted on the way in when data logic select is set
        st_nxt.txbuf = pwdata[7:0] ^ {8{inv}};
        st_nxt.ti = 1'b0;
      end
    end
    // A frame landing in the same cycle keeps the flag set
    if (rd_ok && a == RXB_OFF && !st_r.pslverr && !landed) begin
      st_nxt.ri = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.mode <= MODE_RST;
      st_r.c0 <= CTL0_RST;
      st_r.c1 <= CTL1_RST;
      st_r.brg <= BRG_RST;
      st_r.ti <= 1'b1;
      st_r.txept <= 1'b1;
      st_r.tx_st <= TX_IDLE;
      st_r.rx_st <= RX_IDLE;
      st_r.out_pin <= 1'b1;
      st_r.out_oe <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign serial_out_pin = st_r.out_pin;
  assign serial_out_oe = st_r.out_oe;
  assign tx_irq = st_r.tx_irq;
  assign rx_irq = st_r.rx_irq;
  assign collision_irq = st_r.col_irq;

endmodule
`default_nettype wire

// ---- sc_uart_properties.sv ----
// Port-level assertions for the smart-card serial channel.
`timescale 1ns/1ps
`default_nettype none
module sc_uart_properties
  import sc_uart_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic collision_irq
);
  // ------------------------------------------------------------
  // Control bits shadowed from completed writes
  // ------------------------------------------------------------
  logic wr, ctl_wr, mode_wr, txb_wr;
  logic te_r, re_r, irs_r, ese_r, pol_r, act_r;
  logic [3:0] diff_r;
  assign wr = psel && penable && pready && pwrite;
  assign ctl_wr = wr && paddr == {24'h0, CTL1_OFF};
  assign mode_wr = wr && paddr == {24'h0, MODE_OFF};
  assign txb_wr = wr && paddr == {24'h0, TXB_OFF};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {te_r, re_r, irs_r, ese_r, pol_r, act_r} <= '0;
      diff_r <= '0;
    end else begin
      // History, since the design may register its comparison
      diff_r <= {diff_r[2:0], serial_out_pin ^ serial_in_pin};
      if (ctl_wr) begin
        {ese_r, irs_r} <= {pwdata[C1_ESE], pwdata[C1_IRS]};
        {re_r, te_r} <= {pwdata[C1_RE], pwdata[C1_TE]};
      end
      if (mode_wr) begin
        pol_r <= pwdata[MODE_POLREV];
      end
      if (txb_wr || (mode_wr && pwdata[MODE_POLREV]) || !serial_in_pin) begin
        act_r <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  idle_line_a: assert property (!act_r |-> serial_out_pin)
    else $error("line left idle level before any transfer");
  collision_cause_a: assert property (
    collision_irq |-> (|diff_r) || (serial_out_pin != serial_in_pin))
    else $error("collision flagged with matching levels");
  tx_done_stop_a: assert property (
    tx_irq && irs_r && !pol_r |-> serial_out_pin && $past(serial_out_pin, 8))
    else $error("completion flagged before the stop bit was sent");
  tx_err_delay_a: assert property (
    tx_irq && irs_r && ese_r && !pol_r |-> $past(serial_out_pin, 20))
    else $error("completion not delayed by half a bit");
  tx_hold_a: assert property (
    txb_wr && !te_r && !pol_r |=> serial_out_pin [*8])
    else $error("frame started with transmit disabled");
  rx_enable_a: assert property (rx_irq |-> re_r)
    else $error("frame received with receive disabled");
  rx_pulse_a: assert property (rx_irq |=> !rx_irq)
    else $error("receive request longer than one cycle");
  tx_pulse_a: assert property (tx_irq |=> !tx_irq)
    else $error("transmit request longer than one cycle");
endmodule
`default_nettype wire

// ---- sc_card_model.sv ----
// Behavioural smart card on the shared, pulled-up data line.
`timescale 1ns/1ps
`default_nettype none
module sc_card_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic pclk,
  input wire logic line,
  output logic card_low
);
  initial card_low = 1'b0;
  // The card only pulls low; on release the pull-up sets the level
  task automatic hold(input logic v);
    card_low <= v;
  endtask
  task automatic send(input logic [10:0] lv);
    for (int i = 0; i < 11; i++) begin
      card_low <= !lv[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
  endtask
  // Mid-bit sampling; ok drops if no start bit shows up
  task automatic grab(output logic [10:0] lv, output logic ok);
    int n;
    n = 0;
    lv = '0;
    while (line !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    ok = (n < 400);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      lv[i] = line;
      if (i < 10) repeat (BIT_CYC) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb_sc_uart.sv ----
// Self-checking bench for the smart-card serial channel.
`timescale 1ns/1ps
`default_nettype none
module tb_sc_uart;
  import sc_uart_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ok;
  logic serial_out_pin, serial_out_oe, card_low;
  logic tx_irq, rx_irq, collision_irq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [10:0] lv;
  wire line;
  int n_mismatch = 0;
  int compares = 0;
  int nrx = 0;
  int ncol = 0;
  int c0, c1;
  // Pulled-up shared line: either party can only pull it low
  assign line = !((serial_out_oe && !serial_out_pin) || card_low);
  sc_uart i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(line),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .collision_irq(collision_irq)
  );
  sc_card_model i_card (.pclk(pclk), .line(line), .card_low(card_low));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    nrx <= nrx + int'(rx_irq === 1'b1);
    ncol <= ncol + int'(collision_irq === 1'b1);
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fail(input string nm);
    chk(nm, 32'h1, 32'h0);
    tally_and_finish();
  endtask
  // ------------------------------------------------------------
  // Bus and wait helpers; entered just after a rising edge
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16) fail("apb timeout");
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return tx_irq;
      2: return !line;
      default: return serial_out_pin;
    endcase
  endfunction
  task automatic wfor(input int k, input int lim, output int c);
    c = 0;
    while (sig(k) !== 1'b1) begin
      @(posedge pclk);
      c++;
      if (c > lim) fail("wait timeout");
    end
  endtask
  task automatic cfg(input logic [7:0] m, input logic [7:0] r0,
                     input logic [7:0] r1);
    apb(1'b1, MODE_OFF, {24'h0, m});
    apb(1'b1, CTL0_OFF, {24'h0, r0});
    apb(1'b1, CTL1_OFF, {24'h0, r1});
  endtask
  // Line levels, start bit first
  function automatic logic [10:0] frame(input logic [7:0] d, input logic inv);
    logic [7:0] s;
    s = inv ? ~d : d;
    if (inv) s = {<<{s}};
    return {1'b1, inv ? ~^s : ^s, s, 1'b0};
  endfunction
  task automatic grabchk(input logic [7:0] d, input logic inv);
    i_card.grab(lv, ok);
    chk("frame", {21'h0, frame(d, inv)}, {21'h0, lv & {11{ok}}});
  endtask
  task automatic t_tx(input logic [7:0] d, input logic inv, output int c);
    int col;
    col = ncol;
    apb(1'b1, TXB_OFF, {24'h0, d});
    grabchk(d, inv);
    wfor(0, 400, c);
    chk("no card error", 32'h1, {31'h0, line});
    chk("clean collisions", col, ncol);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, CTL0_OFF, 32'h0);
    chk("ctl0 reset", {24'h0, CTL0_RST} | 32'h08, rd);
    apb(1'b0, CTL1_OFF, 32'h0);
    chk("ctl1 reset", {24'h0, CTL1_RST} | 32'h02, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask
  task automatic t_tx_modes();
    cfg(8'h65, 8'h10, 8'h11);
    t_tx(8'ha6, 1'b0, c0);
    cfg(8'h45, 8'h90, 8'h51);
    t_tx(8'h3b, 1'b1, c1);
    cfg(8'h65, 8'h10, 8'h91);
    t_tx(8'ha6, 1'b0, c1);
    chk("error enable delay", c0 + 8, c1);
  endtask
  task automatic t_te_off();
    cfg(8'h65, 8'h10, 8'h00);
    apb(1'b1, TXB_OFF, 32'h81);
    repeat (40) @(posedge pclk);
    chk("held idle", 32'h1, {31'h0, serial_out_pin});
    apb(1'b1, CTL1_OFF, 32'h11);
    grabchk(8'h81, 1'b0);
    wfor(0, 400, c0);
  endtask
  task automatic t_rx();
    int n0;
    for (int k = 0; k < 2; k++) begin
      if (k == 0) cfg(8'h65, 8'h10, 8'h14);
      else cfg(8'h45, 8'h90, 8'h54);
      n0 = nrx;
      i_card.send(frame(8'hc5, k[0]));
      repeat (4) @(posedge pclk);
      chk("rx request", n0 + 1, nrx);
      apb(1'b0, RXB_OFF, 32'h0);
      chk("rx data", 32'hc5, rd);
    end
  endtask
  task automatic t_err();
    cfg(8'h65, 8'h10, 8'h95);
    i_card.send(frame(8'h5a, 1'b0) ^ 11'h200);
    chk("error low", 32'h0, {31'h0, serial_out_pin});
    apb(1'b0, RXB_OFF, 32'h0);
    chk("parity flags", 32'hc05a, rd);
    apb(1'b1, CTL1_OFF, 32'h14);
    // Own error pulse looks like a start bit; let it land, error output off
    repeat (200) @(posedge pclk);
    apb(1'b0, RXB_OFF, 32'h0);
  endtask
  task automatic t_overrun();
    int n0;
    cfg(8'h65, 8'h10, 8'h14);
    n0 = nrx;
    i_card.send(frame(8'h11, 1'b0));
    i_card.send(frame(8'h22, 1'b0));
    repeat (4) @(posedge pclk);
    chk("overrun request", n0 + 1, nrx);
    apb(1'b0, RXB_OFF, 32'h0);
    chk("overrun data", 32'h9022, rd);
    apb(1'b1, CTL1_OFF, 32'h00);
    n0 = nrx;
    i_card.send(frame(8'h33, 1'b0));
    repeat (4) @(posedge pclk);
    chk("rx disabled", n0, nrx);
  endtask
  task automatic t_pol();
    cfg(8'he5, 8'h10, 8'h11);
    repeat (4) @(posedge pclk);
    chk("inverted idle", 32'h0, {31'h0, serial_out_pin});
    apb(1'b1, TXB_OFF, 32'hff);
    wfor(4, 40, c0);
    repeat (24) @(posedge pclk);
    chk("inverted data", 32'h0, {31'h0, serial_out_pin});
    wfor(0, 400, c0);
    apb(1'b1, MODE_OFF, 32'h65);
  endtask
  task automatic t_collision();
    int n0;
    n0 = ncol;
    i_card.hold(1'b1);
    apb(1'b1, TXB_OFF, 32'hff);
    wfor(0, 400, c0);
    chk("line at completion", 32'h0, {31'h0, line});
    i_card.hold(1'b0);
    chk("collision", 32'h1, {31'h0, ncol > n0});
  endtask
  task automatic t_div();
    apb(1'b1, CTL0_OFF, 32'h31);
    apb(1'b1, BRG_OFF, 32'h1);
    chk("released idle", 32'h0, {31'h0, serial_out_oe});
    apb(1'b1, TXB_OFF, 32'hff);
    wfor(2, 40, c0);
    wfor(4, 200, c0);
    chk("start bit length", 32'd64, c0);
    wfor(0, 2000, c0);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_tx_modes();
    t_te_off();
    t_rx();
    t_err();
    t_overrun();
    t_pol();
    t_collision();
    t_div();
    tally_and_finish();
  end
endmodule
bind sc_uart sc_uart_properties i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .tx_irq(tx_irq), .rx_irq(rx_irq), .collision_irq(collision_irq)
);
`default_nettype wire
